// ==== wide_updown_counter_bank.v ====
// Contract
// R1: a counter keeps counting past a match with its setting value, it never stops or saturates.
// R2: an up-counting counter that reaches its setting value turns its contact on.
// R3: a down-counting counter that reaches its setting value turns its contact off.
// R4: a clear command zeroes the present value and turns the contact off.
// R5: the contact changes only after the scan step running the count instruction has finished.
// R6: each counter has its own direction select bit, off for up and on for down, held as one block.
// R7: the setting value is a signed 32-bit number, given as a constant or from data registers.
// R8: a setting value from data registers is read from two consecutive 16-bit registers.
// R9: of two paired 16-bit registers the lower-numbered one gives the low half.
// R10: a non-retentive counter loses its value at power loss, a retentive one keeps value and contact.
// R11: one up-count at the largest positive value wraps to the most negative value.
// R12: one down-count at the most negative value wraps to the largest positive value.
// R13: each off-to-on edge of the count input adds or subtracts one by the direction bit.
// R14: a direction change acts at the next count edge and leaves the present value alone.
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "wide_counter_consts.vh"
module wide_updown_counter_bank #(
  parameter N_CNT = 8
) (
  input  wire              core_clk_in,
  input  wire              rst_in,
  input  wire              power_loss_in,
  input  wire [N_CNT-1:0]  count_in,
  input  wire              scan_done_in,
  input  wire [7:0]        s_axi_awaddr_in,
  input  wire              s_axi_awvalid_in,
  output wire              s_axi_awready_out,
  input  wire [31:0]       s_axi_wdata_in,
  input  wire [3:0]        s_axi_wstrb_in,
  input  wire              s_axi_wvalid_in,
  output wire              s_axi_wready_out,
  output reg  [1:0]        s_axi_bresp_out,
  output reg               s_axi_bvalid_out,
  input  wire              s_axi_bready_in,
  input  wire [7:0]        s_axi_araddr_in,
  input  wire              s_axi_arvalid_in,
  output wire              s_axi_arready_out,
  output reg  [31:0]       s_axi_rdata_out,
  output reg  [1:0]        s_axi_rresp_out,
  output reg               s_axi_rvalid_out,
  input  wire              s_axi_rready_in,
  output reg  [N_CNT-1:0]  contact_out,
  output wire              irq_out
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  // per-counter state
  reg  [31:0]      pv_q [0:N_CNT-1];
  reg  [31:0]      setv_q [0:N_CNT-1];
  reg  [N_CNT-1:0] pend_q;
  reg  [N_CNT-1:0] pend_val_q;
  reg  [N_CNT-1:0] count_prev_q;
  reg  [N_CNT-1:0] dir_q;
  reg  [N_CNT-1:0] retain_q;
  reg  [N_CNT-1:0] enable_q;

  // configuration seen by software
  reg  [7:0]       sel_q;
  reg  [15:0]      set_lo_q;
  reg  [15:0]      set_hi_q;
  reg  [1:0]       irq_stat_q;
  reg  [1:0]       irq_en_q;

  // write channel holding registers
  reg  [7:0]       awaddr_q;
  reg  [31:0]      wdata_q;
  reg              aw_full_q;
  reg              w_full_q;

  // merge two 16-bit data words, lower-numbered word is the low half
  function [31:0] pair16;
    input [15:0] lo_word;
    input [15:0] hi_word;
    begin
      pair16 = {hi_word, lo_word}; // R8 R9
    end
  endfunction

  // true when the select register names counter idx, compared at full width
  function sel_is;
    input [7:0]  sel;
    input [31:0] idx;
    begin
      sel_is = ({24'h000000, sel} == idx);
    end
  endfunction

  // writable words: aligned, inside the map, and none of the read-only views
  function wr_legal;
    input [7:0] addr;
    begin
      wr_legal = addr <= `WC_IRQ_CLR_ADDR && addr[1:0] == 2'b00 &&
                 addr != `WC_PV_ADDR && addr != `WC_CONTACT_ADDR &&
                 addr != `WC_IRQ_STAT_ADDR;
    end
  endfunction

  // ----------------------------------------------------------------------
  // axi4-lite write side
  // ----------------------------------------------------------------------
  // ready drops while a word is held or a response is still waiting
  assign s_axi_awready_out = !aw_full_q && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_full_q && !s_axi_bvalid_out;
  wire wr_fire = aw_full_q && w_full_q && !s_axi_bvalid_out;

  // the response rises one cycle after both halves are held; the strobe is
  // not looked at because every register is a whole word, which keeps the
  // write path to one decode at the cost of byte writes
  // write address and data are latched independently, either order
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      aw_full_q        <= 1'b0;
      w_full_q         <= 1'b0;
      awaddr_q         <= 8'h00;
      wdata_q          <= 32'h00000000;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= `WC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata_in;
      end
      if (wr_fire) begin
        aw_full_q        <= 1'b0;
        w_full_q         <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_legal(awaddr_q) ? `WC_RESP_OKAY : `WC_RESP_SLVERR;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // command strobes last one cycle, the cycle in which the write is applied
  wire wr_cmd     = wr_fire && awaddr_q == `WC_CMD_ADDR;
  wire cmd_clear  = wr_cmd && wdata_q[`WC_CMD_CLEAR_BIT];
  wire cmd_load   = wr_cmd && wdata_q[`WC_CMD_LOAD_BIT];
  wire cmd_preset = wr_cmd && wdata_q[`WC_CMD_PRESET_BIT];

  // configuration registers; the strobe is ignored, words are whole
  // a direction write only steers the next edge and leaves the present value alone
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      enable_q <= {N_CNT{1'b0}};
      sel_q    <= 8'h00;
      set_lo_q <= 16'h0000;
      set_hi_q <= 16'h0000;
      dir_q    <= {N_CNT{1'b0}};
      retain_q <= {N_CNT{1'b0}};
      irq_en_q <= 2'b00;
    end else if (wr_fire) begin
      case (awaddr_q)
        `WC_CTRL_ADDR:   enable_q <= wdata_q[N_CNT-1:0];
        `WC_SEL_ADDR:    sel_q    <= wdata_q[7:0];
        `WC_SET_LO_ADDR: set_lo_q <= wdata_q[15:0];
        `WC_SET_HI_ADDR: set_hi_q <= wdata_q[15:0];
        `WC_DIR_ADDR:    dir_q    <= wdata_q[N_CNT-1:0]; // R6 R14
        `WC_RETAIN_ADDR: retain_q <= wdata_q[N_CNT-1:0];
        `WC_IRQ_EN_ADDR: irq_en_q <= wdata_q[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------------
  // priority inside one counter, highest first: power loss on a non-retentive
  // counter, the clear command, the preset command, then the count edge
  // a retentive counter under power loss keeps value and contact and ignores
  // its count input; a second match before the next scan end replaces the
  // pending contact value, so only the latest match reaches the contact
  // per-counter event lines, or-ed into the status bits
  wire [N_CNT-1:0] match_ev;
  wire [N_CNT-1:0] wrap_ev;
  genvar gi;
  generate
    for (gi = 0; gi < N_CNT; gi = gi + 1) begin : g_cnt
      // count edge, ignored while power is lost so a frozen counter raises no event
      wire        edge_w = enable_q[gi] && count_in[gi] && !count_prev_q[gi] &&
                           !power_loss_in; // R13
      // commands aimed at this counter through the select register
      wire        hit_w  = cmd_clear && sel_is(sel_q, gi);
      wire        ld_w   = cmd_load && sel_is(sel_q, gi);
      wire        pre_w  = cmd_preset && sel_is(sel_q, gi);
      // an edge that really moves the count: clear and preset both beat it
      wire        cnt_w  = edge_w && !hit_w && !pre_w;
      // next value; plain 32-bit arithmetic wraps at both signed ends
      wire [31:0] nxt_w  = dir_q[gi] ? pv_q[gi] - 32'h00000001 // R11 R12
                                     : pv_q[gi] + 32'h00000001;
      // events for the status register
      assign match_ev[gi] = cnt_w && nxt_w == setv_q[gi];
      assign wrap_ev[gi]  = cnt_w &&
                            pv_q[gi] == (dir_q[gi] ? `WC_PV_MIN : `WC_PV_MAX);
      // present value, setting value and pending contact state
      always @(posedge core_clk_in) begin
        if (rst_in) begin
          pv_q[gi]         <= 32'h00000000;
          setv_q[gi]       <= 32'h00000000;
          pend_q[gi]       <= 1'b0;
          pend_val_q[gi]   <= 1'b0;
          contact_out[gi]  <= 1'b0;
          count_prev_q[gi] <= 1'b0;
        end else begin
          // previous level, so a level held high counts only once
          count_prev_q[gi] <= count_in[gi];
          if (ld_w) begin
            setv_q[gi] <= pair16(set_lo_q, set_hi_q); // R7
          end
          // non-retentive counters drop value and contact while power is lost
          if (power_loss_in && !retain_q[gi]) begin
            pv_q[gi]        <= 32'h00000000; // R10
            contact_out[gi] <= 1'b0;
            pend_q[gi]      <= 1'b0;
          end else if (hit_w) begin
            pv_q[gi]        <= 32'h00000000; // R4
            contact_out[gi] <= 1'b0;
            pend_q[gi]      <= 1'b0;
          end else if (pre_w) begin
            pv_q[gi] <= pair16(set_lo_q, set_hi_q); // preset, contact left as it is
          end else if (!power_loss_in) begin
            if (edge_w) begin
              pv_q[gi] <= nxt_w; // R1
            end
            // a match in the cycle of a scan end waits for the following scan end
            if (match_ev[gi]) begin
              pend_q[gi]     <= 1'b1;
              pend_val_q[gi] <= !dir_q[gi]; // R2 R3
            end else if (scan_done_in && pend_q[gi]) begin
              pend_q[gi]      <= 1'b0;
              contact_out[gi] <= pend_val_q[gi]; // R5
            end
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // interrupts: sticky, set wins over clear
  // ----------------------------------------------------------------------
  // an event in the cycle of a clear of its bit leaves the bit set
  wire [1:0] irq_set = {|wrap_ev, |match_ev};
  wire [1:0] irq_clr = (wr_fire && awaddr_q == `WC_IRQ_CLR_ADDR) ? wdata_q[1:0] : 2'b00;
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      irq_stat_q <= 2'b00;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end
  // level output, high while any enabled status bit is set
  assign irq_out = |(irq_stat_q & irq_en_q);

  // ----------------------------------------------------------------------
  // axi4-lite read side
  // ----------------------------------------------------------------------
  // reads answer the cycle after the address is taken; a second read waits
  // until the first answer has been accepted
  assign s_axi_arready_out = !s_axi_rvalid_out;
  // views of the selected counter; an index past the bank reads as zero
  wire [31:0] pv_sel   = ({24'h000000, sel_q} < N_CNT) ? pv_q[sel_q[2:0]] : 32'h00000000;
  wire [31:0] setv_sel = ({24'h000000, sel_q} < N_CNT) ? setv_q[sel_q[2:0]] : 32'h00000000;

  // one read at a time; unmapped reads give zero and slverr
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h00000000;
      s_axi_rresp_out  <= `WC_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out  <= `WC_RESP_OKAY;
      s_axi_rdata_out  <= 32'h00000000;
      // unmapped addresses fall to the default and answer slverr
      case (s_axi_araddr_in)
        `WC_CTRL_ADDR:     s_axi_rdata_out[N_CNT-1:0] <= enable_q;
        `WC_SEL_ADDR:      s_axi_rdata_out[7:0]       <= sel_q;
        `WC_CMD_ADDR:      s_axi_rdata_out            <= 32'h00000000;
        `WC_SET_LO_ADDR:   s_axi_rdata_out[15:0]      <= set_lo_q;
        `WC_SET_HI_ADDR:   s_axi_rdata_out[15:0]      <= set_hi_q;
        `WC_DIR_ADDR:      s_axi_rdata_out[N_CNT-1:0] <= dir_q;
        `WC_RETAIN_ADDR:   s_axi_rdata_out[N_CNT-1:0] <= retain_q;
        `WC_PV_ADDR:       s_axi_rdata_out            <= pv_sel;
        `WC_CONTACT_ADDR:  s_axi_rdata_out[N_CNT-1:0] <= contact_out;
        `WC_IRQ_STAT_ADDR: s_axi_rdata_out[1:0]       <= irq_stat_q;
        `WC_IRQ_EN_ADDR:   s_axi_rdata_out[1:0]       <= irq_en_q;
        `WC_IRQ_CLR_ADDR:  s_axi_rdata_out            <= 32'h00000000;
        `WC_SETV_ADDR:     s_axi_rdata_out            <= setv_sel;
        default:           s_axi_rresp_out            <= `WC_RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end
endmodule // wide_updown_counter_bank
`default_nettype wire

// ==== wide_counter_consts.vh ====
`ifndef WIDE_COUNTER_CONSTS_VH
`define WIDE_COUNTER_CONSTS_VH
// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define WC_CTRL_ADDR     8'h00
`define WC_SEL_ADDR      8'h04
`define WC_CMD_ADDR      8'h08
`define WC_SET_LO_ADDR   8'h0c
`define WC_SET_HI_ADDR   8'h10
`define WC_DIR_ADDR      8'h14
`define WC_RETAIN_ADDR   8'h18
`define WC_PV_ADDR       8'h1c
`define WC_CONTACT_ADDR  8'h20
`define WC_IRQ_STAT_ADDR 8'h24
`define WC_IRQ_EN_ADDR   8'h28
`define WC_IRQ_CLR_ADDR  8'h2c
`define WC_SETV_ADDR     8'h30
// ----------------------------------------------------------------------
// command register fields
// ----------------------------------------------------------------------
`define WC_CMD_CLEAR_BIT  0
`define WC_CMD_LOAD_BIT   1
`define WC_CMD_PRESET_BIT 2
// ----------------------------------------------------------------------
// interrupt status fields
// ----------------------------------------------------------------------
`define WC_IRQ_MATCH_BIT  0
`define WC_IRQ_WRAP_BIT   1
// ----------------------------------------------------------------------
// values
// ----------------------------------------------------------------------
`define WC_PV_MAX         32'h7fffffff
`define WC_PV_MIN         32'h80000000
`define WC_RESP_OKAY      2'b00
`define WC_RESP_SLVERR    2'b10
`endif

// ==== wide_counter_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module wide_counter_chk #(
  parameter N_CNT = 8
) (
  input wire logic             core_clk_in,
  input wire logic             rst_in,
  input wire logic             scan_done_in,
  input wire logic             s_axi_awvalid_in,
  input wire logic             s_axi_awready_out,
  input wire logic             s_axi_wvalid_in,
  input wire logic             s_axi_wready_out,
  input wire logic             s_axi_bvalid_out,
  input wire logic             s_axi_bready_in,
  input wire logic             s_axi_arvalid_in,
  input wire logic             s_axi_arready_out,
  input wire logic             s_axi_rvalid_out,
  input wire logic             s_axi_rready_in,
  input wire logic [N_CNT-1:0] contact_out,
  input wire logic             irq_out
);
  // one clock domain, so clock and reset are given once for all properties
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // a contact may only switch on right after a scan has ended
  chk_contact_scan:
  assert property (|(contact_out & ~$past(contact_out)) |-> $past(scan_done_in)) else $error("early contact");
  chk_reset_quiet:
  assert property ($fell(rst_in) |-> !contact_out && !s_axi_bvalid_out && !s_axi_rvalid_out && !irq_out) else $error("reset");
  chk_read_answer:
  assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out) else $error("late read");
  chk_write_answer:
  assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
    |-> ##[1:3] s_axi_bvalid_out) else $error("late write");
  chk_write_refuse:
  assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out) else $error("aw busy");
  chk_read_refuse:
  assert property (s_axi_rvalid_out |-> !s_axi_arready_out) else $error("ar busy");
  chk_bvalid_once:
  assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out) else $error("bvalid");
  chk_rvalid_once:
  assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out) else $error("rvalid");
endmodule // wide_counter_chk
bind wide_updown_counter_bank wide_counter_chk #(.N_CNT(N_CNT)) i_chk (.*);
`default_nettype wire

// ==== ctrl_program_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module ctrl_program_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] pulse_mask_in,
  input  wire logic       pulse_go_in,
  output wire logic [7:0] count_out,
  output wire logic       scan_done_out
);
  logic [1:0] step_q = 2'h0;
  logic [7:0] count_q = 8'h00;
  logic       scan_q = 1'b0;
  // a scan ends every fourth clock; one go raises each masked count line for one cycle,
  // so every request gives exactly one off-to-on edge
  always @(posedge clk_in) begin
    if (rst_in) begin
      step_q <= 2'h0;
      count_q <= 8'h00;
      scan_q <= 1'b0;
    end else begin
      step_q <= step_q + 2'h1;
      scan_q <= (step_q == 2'h3);
      count_q <= pulse_go_in ? pulse_mask_in : 8'h00;
    end
  end
  assign count_out = count_q;
  assign scan_done_out = scan_q;
endmodule // ctrl_program_model
`default_nettype wire

// ==== wide_updown_counter_bank_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "wide_counter_consts.vh"
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module wide_updown_counter_bank_tb_top;
  logic        core_clk_in = 1'b0, rst_in = 1'b1, power_loss_in = 1'b0, pulse_go = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, pulse_mask = 8'h00, count_in, contact;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic [1:0]  bresp, rresp;
  logic        scan_done, awready, wready, bvalid, arready, rvalid, irq;
  int          errors = 0, n_tests = 0, cyc = 0;
  initial forever #2 core_clk_in = ~core_clk_in;
  wide_updown_counter_bank #(.N_CNT(8)) i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .power_loss_in(power_loss_in), .count_in(count_in), .scan_done_in(scan_done),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(1'b1), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(1'b1), .contact_out(contact), .irq_out(irq));
  ctrl_program_model i_prog (.clk_in(core_clk_in), .rst_in(rst_in), .pulse_mask_in(pulse_mask),
    .pulse_go_in(pulse_go), .count_out(count_in), .scan_done_out(scan_done));
  task automatic report_and_stop;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // write cycle: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge core_clk_in);
      if (awready === 1'b1 && !ta) begin ta = 1'b1; awvalid <= 1'b0; end
      if (wready === 1'b1 && !tw) begin tw = 1'b1; wvalid <= 1'b0; end
    end while (!(ta && tw));
    do @(posedge core_clk_in); while (bvalid !== 1'b1);
    `CHECK(bresp, er)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge core_clk_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk_in); while (rvalid !== 1'b1);
    `CHECK(rdata, x)
    `CHECK(rresp, er)
  endtask
  // one count edge per step, then time for the pv update and the next scan end
  task automatic pulse(input logic [7:0] m, input int n);
    repeat (n) begin
      pulse_mask <= m;
      pulse_go <= 1'b1;
      @(posedge core_clk_in);
      pulse_go <= 1'b0;
      repeat (8) @(posedge core_clk_in);
    end
  endtask
  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 20000) begin errors++; report_and_stop; end
  end
  localparam logic [1:0] OK = `WC_RESP_OKAY;
  initial begin
    repeat (6) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    rd(`WC_CONTACT_ADDR, 32'h0, OK);
    wr(`WC_CTRL_ADDR, 32'h3, OK);
    wr(`WC_SET_LO_ADDR, 32'hfffb, OK);
    wr(`WC_SET_HI_ADDR, 32'hffff, OK);
    wr(`WC_CMD_ADDR, 32'h2, OK);
    rd(`WC_SETV_ADDR, 32'hfffffffb, OK);
    wr(`WC_IRQ_EN_ADDR, 32'h1, OK);
    wr(`WC_DIR_ADDR, 32'h1, OK);
    pulse(8'h03, 6); // counter 0 down, counter 1 up
    rd(`WC_PV_ADDR, 32'hfffffffa, OK);
    `CHECK(contact[0], 1'b0)
    `CHECK(irq, 1'b1)
    wr(`WC_IRQ_EN_ADDR, 32'h0, OK);
    `CHECK(irq, 1'b0)
    wr(`WC_IRQ_EN_ADDR, 32'h1, OK);
    wr(`WC_IRQ_CLR_ADDR, 32'h1, OK);
    `CHECK(irq, 1'b0)
    wr(`WC_SEL_ADDR, 32'h1, OK);
    rd(`WC_PV_ADDR, 32'h6, OK);
    wr(`WC_SEL_ADDR, 32'h0, OK);
    wr(`WC_DIR_ADDR, 32'h0, OK);
    rd(`WC_PV_ADDR, 32'hfffffffa, OK);
    pulse(8'h01, 1);
    `CHECK(contact[0], 1'b1)
    pulse(8'h01, 1);
    rd(`WC_PV_ADDR, 32'hfffffffc, OK);
    `CHECK(contact[0], 1'b1)
    wr(`WC_CMD_ADDR, 32'h1, OK);
    rd(`WC_PV_ADDR, 32'h0, OK);
    `CHECK(contact[0], 1'b0)
    wr(`WC_SET_LO_ADDR, 32'h2, OK);
    wr(`WC_SET_HI_ADDR, 32'h0, OK);
    wr(`WC_CMD_ADDR, 32'h2, OK);
    pulse(8'h01, 3);
    `CHECK(contact[0], 1'b1)
    wr(`WC_DIR_ADDR, 32'h1, OK);
    pulse(8'h01, 1);
    `CHECK(contact[0], 1'b0)
    wr(`WC_RETAIN_ADDR, 32'h1, OK);
    power_loss_in <= 1'b1;
    @(posedge core_clk_in);
    rd(`WC_PV_ADDR, 32'h2, OK);
    power_loss_in <= 1'b0;
    wr(`WC_RETAIN_ADDR, 32'h0, OK);
    power_loss_in <= 1'b1;
    @(posedge core_clk_in);
    rd(`WC_PV_ADDR, 32'h0, OK);
    power_loss_in <= 1'b0;
    rd(8'h3c, 32'h0, `WC_RESP_SLVERR);
    wr(`WC_PV_ADDR, 32'h5, `WC_RESP_SLVERR);
    rd(`WC_PV_ADDR, 32'h0, OK);
    // preset to the most negative value, then cross both signed ends
    wr(`WC_IRQ_CLR_ADDR, 32'h3, OK);
    wr(`WC_SET_LO_ADDR, 32'h0000, OK);
    wr(`WC_SET_HI_ADDR, 32'h8000, OK);
    wr(`WC_CMD_ADDR, 32'h4, OK);
    pulse(8'h01, 1);
    rd(`WC_PV_ADDR, `WC_PV_MAX, OK);
    wr(`WC_DIR_ADDR, 32'h0, OK);
    pulse(8'h01, 1);
    rd(`WC_PV_ADDR, `WC_PV_MIN, OK);
    rd(`WC_IRQ_STAT_ADDR, 32'h2, OK);
    wr(`WC_IRQ_EN_ADDR, 32'h2, OK);
    `CHECK(irq, 1'b1)
    report_and_stop;
  end
endmodule // wide_updown_counter_bank_tb_top
`default_nettype wire
